// ==== mfs_regs.svh ====
// Purpose: Constants of the micro fetch and execute sequencer
// Assumes: 250 MHz ref clock; micro clock period 250 ns (two halves)
// Notes:   Field layout of the 16-bit micro is op, source, sink, width
`ifndef MFS_REGS_SVH
`define MFS_REGS_SVH

// Micro field positions
`define MFS_OP_HI        15
`define MFS_OP_LO        12
`define MFS_SRC_HI       11
`define MFS_SRC_LO       7
`define MFS_DST_HI       6
`define MFS_DST_LO       2
`define MFS_WID_HI       1
`define MFS_WID_LO       0

// Codes
`define MFS_OP_MOVE      4'h1
`define MFS_SRC_DEC_SUM  5'h1e
`define MFS_SRC_DEC_DIFF 5'h1f
`define MFS_SRC_TAPE     5'h1d
`define MFS_DST_MAR      5'h1e
`define MFS_DST_MICRO    5'h1f
`define MFS_WID_24       2'h0
`define MFS_WID_16       2'h1
`define MFS_WID_4        2'h2
`define MFS_NOOP         16'h0000

// Execution lengths in micro clock periods
`define MFS_LEN_BASE     3'h2
`define MFS_LEN_DEC      3'h3
`define MFS_LEN_MAR      3'h4
`define MFS_LEN_DEC_MAR  3'h5
`define MFS_REFRESH_LEN  3'h2

// Timing: figures in ns, counts of 4 ns cycles derived from them
`define MFS_CLK_NS       4
`define MFS_HALF_NS      125
`define MFS_HALF_CYC     ((`MFS_HALF_NS + `MFS_CLK_NS - 1) / `MFS_CLK_NS)
`define MFS_RD_VALID_NS  434
`define MFS_RD_HOLD_NS   511
`define MFS_RD_VALID_CYC \
  ((`MFS_RD_VALID_NS + `MFS_CLK_NS - 1) / `MFS_CLK_NS)
`define MFS_RD_HOLD_CYC  (`MFS_RD_HOLD_NS / `MFS_CLK_NS)

`endif

// ==== mfs_pkg.sv ====
// Purpose: Types of the micro fetch and execute sequencer
// Assumes: Constants come from mfs_regs.svh
// Notes:   Types only
package mfs_pkg;
  typedef enum logic [1:0] {
    MFS_EXEC,
    MFS_TAPE_WAIT,
    MFS_REFRESH
  } mfs_state_e;
  typedef logic [15:0] mfs_micro_t;
  typedef logic [23:0] mfs_word_t;
endpackage

// ==== mfs_phase_gen.sv ====
// Purpose: Half-period tick of the micro clock, derived from ref clock
// Assumes: HALF_CYC of at least 2
// Notes:   half_out 0 is the low half, 1 the high half of the clock
`timescale 1ns/1ps
module mfs_phase_gen #(
  parameter int HALF_CYC = 32
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  output logic      tick_out,
  output logic      half_out
);
  logic [11:0] cnt_r;

  // Counts one half period and flips the half on each tick
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r    <= 12'h000;
      half_out <= 1'b0;
    end else if (!run_in) begin
      cnt_r    <= 12'h000;
      half_out <= 1'b0;
    end else if (cnt_r == 12'(HALF_CYC - 1)) begin
      cnt_r    <= 12'h000;
      half_out <= ~half_out;
    end else begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  // Tick marks the last cycle of each half
  assign tick_out = run_in && (cnt_r == 12'(HALF_CYC - 1));
endmodule

// ==== mfs_sequencer.sv ====
// Purpose: Fetches micros into the latch, executes them from the micro
//          register and times the register move micro
// Assumes: Main store sits outside; phases T0..T9 are half periods
// Notes:   Overview of operation below
`timescale 1ns/1ps
`include "mfs_regs.svh"
module mfs_sequencer #(
  parameter int HALF_CYC = `MFS_HALF_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        run_state_level_in,
  input  wire logic        halt_mode_in,
  input  wire logic [15:0] halt_micro_in,
  input  wire logic [31:0] mem_read_data_in,
  input  wire logic        mar_bit4_in,
  input  wire logic        refresh_req_in,
  input  wire logic        tape_full_in,
  input  wire logic [23:0] exchange_in,
  output logic      [15:0] micro_bus_out,
  output logic      [15:0] micro_reg_out,
  output logic             hold_release_level_out,
  output logic             micro_finish_out,
  output logic             fetch_latch_strobe_out,
  output logic             memory_start_ff_out,
  output logic             source_enable_phase_out,
  output logic             sink_enable_phase_out,
  output logic             local_mem_write_pulse_out,
  output logic      [4:0]  src_addr_out,
  output logic      [4:0]  dst_addr_out,
  output logic      [23:0] exchange_hold_buffer_out,
  output logic             mar_load_out,
  output logic             move_refused_out,
  output logic      [3:0]  phase_out
);
  mfs_pkg::mfs_state_e state_r;
  mfs_pkg::mfs_micro_t micro_r;
  mfs_pkg::mfs_micro_t micro_exec;
  mfs_pkg::mfs_micro_t micro_nxt;
  logic [31:0] latch_r;
  logic [2:0]  s_cnt_r;
  logic [2:0]  rf_cnt_r;
  logic [7:0]  rd_cnt_r;
  logic        rd_busy_r;
  logic        tape_ready_r;
  logic        refresh_pend_r;
  logic        active;
  logic        tick;
  logic        half;
  logic        main_edge;
  logic        inv_edge;
  logic        is_move;
  logic        src_dec;
  logic        src_tape;
  logic        dst_mar;
  logic        dst_micro;
  logic        refused;
  logic [2:0]  mv_len;
  logic [2:0]  len;
  logic [3:0]  t_idx;
  logic        in_move;
  logic        load_fire;
  logic        refresh_done;
  logic        refetch;
  logic [23:0] mask;

  assign active = run_state_level_in || halt_mode_in;

  mfs_phase_gen #(
    .HALF_CYC (HALF_CYC)
  ) u_phase (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .run_in     (active),
    .tick_out   (tick),
    .half_out   (half)
  );

  // Trailing edges of the main clock and of its inverse
  assign main_edge = tick && half;
  assign inv_edge  = tick && !half;

  // Micro presented for decode and to the bus
  assign hold_release_level_out = (state_r == mfs_pkg::MFS_EXEC);
  always_comb begin
    if (run_state_level_in && hold_release_level_out) begin
      micro_bus_out = micro_r;
    end else if (halt_mode_in) begin
      micro_bus_out = halt_micro_in;
    end else begin
      micro_bus_out = `MFS_NOOP;
    end
  end
  assign micro_exec    = halt_mode_in ? halt_micro_in : micro_r;
  assign micro_reg_out = micro_r;

  // Decode of the register move micro
  assign is_move  = micro_exec[`MFS_OP_HI:`MFS_OP_LO] == `MFS_OP_MOVE;
  assign src_dec  = is_move &&
    (micro_exec[`MFS_SRC_HI:`MFS_SRC_LO] == `MFS_SRC_DEC_SUM ||
     micro_exec[`MFS_SRC_HI:`MFS_SRC_LO] == `MFS_SRC_DEC_DIFF);
  assign src_tape = is_move &&
    micro_exec[`MFS_SRC_HI:`MFS_SRC_LO] == `MFS_SRC_TAPE;
  assign dst_mar  = is_move &&
    micro_exec[`MFS_DST_HI:`MFS_DST_LO] == `MFS_DST_MAR;
  assign dst_micro = is_move &&
    micro_exec[`MFS_DST_HI:`MFS_DST_LO] == `MFS_DST_MICRO;
  assign refused = run_state_level_in && !halt_mode_in &&
                   src_tape && dst_micro;
  assign move_refused_out = refused;

  // Periods of the move itself and of the whole micro
  assign mv_len = src_dec ? `MFS_LEN_DEC : `MFS_LEN_BASE;
  always_comb begin
    if (src_dec && dst_mar) begin
      len = `MFS_LEN_DEC_MAR;
    end else if (dst_mar) begin
      len = `MFS_LEN_MAR;
    end else begin
      len = mv_len;
    end
  end

  // Phase index T0.. within the micro
  assign t_idx     = {s_cnt_r, half};
  assign phase_out = t_idx;
  assign in_move   = is_move && hold_release_level_out &&
                     (!src_tape || tape_ready_r);

  // Source and sink timing of the move
  always_comb begin
    source_enable_phase_out = in_move &&
      (t_idx <= {mv_len, 1'b0} - 4'h2);
    sink_enable_phase_out   = in_move && !refused &&
      (t_idx == {mv_len, 1'b0} - 4'h1);
    local_mem_write_pulse_out = sink_enable_phase_out;
  end
  assign src_addr_out = source_enable_phase_out ?
    micro_exec[`MFS_SRC_HI:`MFS_SRC_LO] : 5'h00;
  assign dst_addr_out = sink_enable_phase_out ?
    micro_exec[`MFS_DST_HI:`MFS_DST_LO] : 5'h00;

  // Finish in the last period of the decoded length
  assign micro_finish_out = hold_release_level_out &&
    (!src_tape || tape_ready_r) &&
    (!is_move ? s_cnt_r == `MFS_LEN_BASE - 3'h1
              : s_cnt_r == len - 3'h1);
  // After a refresh no-op the next micro loads at once, no replay
  assign refresh_done = main_edge && state_r == mfs_pkg::MFS_REFRESH &&
                        rf_cnt_r == `MFS_REFRESH_LEN - 3'h1;
  assign load_fire = (main_edge && micro_finish_out && !refresh_pend_r) ||
                     refresh_done;
  assign refetch   = main_edge && in_move && dst_mar &&
                     (s_cnt_r == mv_len - 3'h1);
  assign mar_load_out = refetch;

  // Width mask of the moved data
  always_comb begin
    case (micro_exec[`MFS_WID_HI:`MFS_WID_LO])
      `MFS_WID_16: mask = 24'h00ffff;
      `MFS_WID_4:  mask = 24'h00000f;
      default:     mask = 24'hffffff;
    endcase
  end

  // Exchange hold buffer on the inverted clock trailing edge
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      exchange_hold_buffer_out <= 24'h000000;
    end else if (inv_edge && source_enable_phase_out) begin
      exchange_hold_buffer_out <= exchange_in & mask;
    end
  end

  // Next micro: selected latch half, ORed with a move into it
  always_comb begin
    micro_nxt = mar_bit4_in ? latch_r[31:16] : latch_r[15:0];
    if (dst_micro && !refused) begin
      micro_nxt = micro_nxt | exchange_hold_buffer_out[15:0];
    end
  end

  // Micro register changes only on the finishing edge or on the last edge of a refresh no-op
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      micro_r <= `MFS_NOOP;
    end else if (load_fire) begin
      micro_r <= micro_nxt;
    end
  end

  // Period counter, tape wait and refresh no-op
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r      <= mfs_pkg::MFS_EXEC;
      s_cnt_r      <= 3'h0;
      rf_cnt_r     <= 3'h0;
      tape_ready_r <= 1'b0;
    end else if (main_edge) begin
      case (state_r)
        mfs_pkg::MFS_EXEC: begin
          if (micro_finish_out && refresh_pend_r) begin
            state_r  <= mfs_pkg::MFS_REFRESH;
            rf_cnt_r <= 3'h0;
          end else if (micro_finish_out) begin
            s_cnt_r      <= 3'h0;
            tape_ready_r <= 1'b0;
          end else if (src_tape && !tape_ready_r) begin
            state_r <= mfs_pkg::MFS_TAPE_WAIT;
          end else begin
            s_cnt_r <= s_cnt_r + 3'h1;
          end
        end
        mfs_pkg::MFS_TAPE_WAIT: begin
          if (tape_full_in) begin
            state_r      <= mfs_pkg::MFS_EXEC;
            tape_ready_r <= 1'b1;
            s_cnt_r      <= 3'h0;
          end
        end
        mfs_pkg::MFS_REFRESH: begin
          if (rf_cnt_r == `MFS_REFRESH_LEN - 3'h1) begin
            state_r      <= mfs_pkg::MFS_EXEC;
            s_cnt_r      <= 3'h0;
            tape_ready_r <= 1'b0;
          end else begin
            rf_cnt_r <= rf_cnt_r + 3'h1;
          end
        end
        default: state_r <= mfs_pkg::MFS_EXEC;
      endcase
    end
  end

  // Refresh request held until its no-op has begun
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      refresh_pend_r <= 1'b0;
    end else if (refresh_req_in) begin
      refresh_pend_r <= 1'b1;
    end else if (main_edge && state_r == mfs_pkg::MFS_REFRESH) begin
      refresh_pend_r <= 1'b0;
    end
  end

  // Memory start on every load and on an address register refetch
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      memory_start_ff_out <= 1'b0;
    end else begin
      memory_start_ff_out <= load_fire || refetch;
    end
  end

  // Read timer places the latch strobe inside the data window
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_cnt_r  <= 8'h00;
      rd_busy_r <= 1'b0;
    end else if (memory_start_ff_out) begin
      rd_cnt_r  <= 8'h01;
      rd_busy_r <= 1'b1;
    end else if (rd_busy_r) begin
      rd_cnt_r  <= rd_cnt_r + 8'h01;
      rd_busy_r <= rd_cnt_r != 8'(`MFS_RD_HOLD_CYC);
    end
  end
  assign fetch_latch_strobe_out = rd_busy_r &&
    rd_cnt_r == 8'(`MFS_RD_VALID_CYC);

  // Micro latch register
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      latch_r <= 32'h00000000;
    end else if (fetch_latch_strobe_out) begin
      latch_r <= mem_read_data_in;
    end
  end

  sequence s_load;
    load_fire;
  endsequence
  sequence s_start_pulse;
    memory_start_ff_out ##1 !memory_start_ff_out;
  endsequence

  property p_micro_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
      !load_fire |=> $stable(micro_r);
  endproperty
  a_micro_hold: assert property (p_micro_hold)
    else $error("micro register changed outside a load");

  property p_bus_gate;
    @(posedge ref_clk_in) disable iff (rst_in)
      !halt_mode_in && !(run_state_level_in && hold_release_level_out)
      |-> micro_bus_out == `MFS_NOOP;
  endproperty
  a_bus_gate: assert property (p_bus_gate)
    else $error("micro register reached bus while gated off");

  property p_halt_src;
    @(posedge ref_clk_in) disable iff (rst_in)
      halt_mode_in && !run_state_level_in
      |-> micro_bus_out == halt_micro_in;
  endproperty
  a_halt_src: assert property (p_halt_src)
    else $error("halt micro not on distribution bus");

  property p_plain_len;
    @(posedge ref_clk_in) disable iff (rst_in)
      load_fire && is_move && !src_dec && !dst_mar && !src_tape
      |-> s_cnt_r == 3'h1;
  endproperty
  a_plain_len: assert property (p_plain_len)
    else $error("plain move did not finish in two periods");

  property p_dec_mar_len;
    @(posedge ref_clk_in) disable iff (rst_in)
      load_fire && src_dec && dst_mar |-> s_cnt_r == 3'h4;
  endproperty
  a_dec_mar_len: assert property (p_dec_mar_len)
    else $error("decimal move to address register not five periods");

  property p_start;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_load |=> s_start_pulse;
  endproperty
  a_start: assert property (p_start)
    else $error("memory start not set by the loading edge");

  property p_latch;
    @(posedge ref_clk_in) disable iff (rst_in)
      fetch_latch_strobe_out |=> latch_r == $past(mem_read_data_in);
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch missed the read word");

  property p_sink;
    @(posedge ref_clk_in) disable iff (rst_in)
      sink_enable_phase_out |-> local_mem_write_pulse_out &&
        !source_enable_phase_out &&
        t_idx == {mv_len, 1'b0} - 4'h1;
  endproperty
  a_sink: assert property (p_sink)
    else $error("sink phase wrong");

  property p_refused;
    @(posedge ref_clk_in) disable iff (rst_in)
      refused |-> !sink_enable_phase_out;
  endproperty
  a_refused: assert property (p_refused)
    else $error("refused move reached its sink");

  property p_refresh;
    @(posedge ref_clk_in) disable iff (rst_in)
      main_edge && micro_finish_out && refresh_pend_r
      |=> (!hold_release_level_out && !load_fire) [*8];
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh no-op cut short");
endmodule

// ==== mfs_main_store.sv ====
// Purpose: Main store model answering micro fetch reads
// Assumes: One read launched by each memory start pulse
// Notes:   Word under test comes in on word_in; junk outside the window
`timescale 1ns/1ps
`include "mfs_regs.svh"
module mfs_main_store (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic        slow_in,
  input  wire logic [31:0] word_in,
  output logic      [31:0] rd_data_out
);
  int unsigned age_r;
  logic [31:0] junk_r;
  logic        valid;
  // Age of the read in ref cycles since the start pulse
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      age_r <= 0;
    end else if (start_in) begin
      age_r <= 1;
    end else if (age_r != 0 && age_r < 200) begin
      age_r <= age_r + 1;
    end
  end
  // Toggling junk so a stale sample never looks right
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      junk_r <= 32'h5a3c96e1;
    end else begin
      junk_r <= ~junk_r;
    end
  end
  // Prompt answers early, slow only at the latest legal cycle
  assign valid = age_r <= `MFS_RD_HOLD_CYC &&
    age_r >= (slow_in ? `MFS_RD_VALID_CYC : `MFS_RD_VALID_CYC - 8);
  assign rd_data_out = valid ? word_in : junk_r;
endmodule

// ==== mfs_sequencer_test.sv ====
// Purpose: Self-checking bench of the micro fetch and execute sequencer
// Assumes: Half period of 32 ref cycles, one micro period 64 cycles
// Notes:   Micros are fed through the main store model, checked per load
`timescale 1ns/1ps
`include "mfs_regs.svh"
module mfs_sequencer_test;
  localparam int H = `MFS_HALF_CYC;
  localparam int P = 2 * H;
  logic        ref_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        run_state_level_in = 1'b1;
  logic        halt_mode_in = 1'b0;
  logic [15:0] halt_micro_in = 16'h0000;
  logic        mar_bit4_in = 1'b0;
  logic        refresh_req_in = 1'b0;
  logic        tape_full_in = 1'b0;
  logic [23:0] exchange_in = 24'h000000;
  logic [31:0] mem_word = 32'h00000000;
  logic        slow = 1'b0;
  logic [31:0] rd_data;
  logic [15:0] bus, ureg;
  logic [23:0] hbuf;
  logic [4:0]  sa, da;
  logic        hold, fin, stb, mst, sen, ken, wen, refused, mload;
  logic [3:0]  ph;
  int unsigned cyc, c0, tape_at, seg_len, n_pulse;
  int unsigned ref_at = 32'hffffffff;
  int          fail_count, num_checks;
  logic        started, mar_mid, part2, tape_on, mon_en;
  logic [23:0] ex_cur;
  mfs_pkg::mfs_micro_t cur, exp_nxt;
  mfs_pkg::mfs_micro_t plan[$];

  mfs_sequencer #(.HALF_CYC(H)) dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .run_state_level_in(run_state_level_in), .halt_mode_in(halt_mode_in),
    .halt_micro_in(halt_micro_in), .mem_read_data_in(rd_data),
    .mar_bit4_in(mar_bit4_in), .refresh_req_in(refresh_req_in),
    .tape_full_in(tape_full_in), .exchange_in(exchange_in),
    .micro_bus_out(bus), .micro_reg_out(ureg),
    .hold_release_level_out(hold), .micro_finish_out(fin),
    .fetch_latch_strobe_out(stb), .memory_start_ff_out(mst),
    .source_enable_phase_out(sen), .sink_enable_phase_out(ken),
    .local_mem_write_pulse_out(wen), .src_addr_out(sa),
    .dst_addr_out(da), .exchange_hold_buffer_out(hbuf),
    .mar_load_out(mload), .move_refused_out(refused), .phase_out(ph));

  mfs_main_store mem (.clk_in(ref_clk_in), .rst_in(rst_in), .start_in(mst),
    .slow_in(slow), .word_in(mem_word), .rd_data_out(rd_data));

  // Clock of 4 ns
  always #2 ref_clk_in = ~ref_clk_in;

  // Decode helpers of the bench's own
  function automatic logic mv(mfs_pkg::mfs_micro_t m);
    return m[15:12] == `MFS_OP_MOVE;
  endfunction
  function automatic logic dec(mfs_pkg::mfs_micro_t m);
    return mv(m) && m[11:8] == 4'hf;
  endfunction
  function automatic logic mar(mfs_pkg::mfs_micro_t m);
    return mv(m) && m[6:2] == `MFS_DST_MAR;
  endfunction
  function automatic logic tape(mfs_pkg::mfs_micro_t m);
    return mv(m) && m[11:7] == `MFS_SRC_TAPE;
  endfunction
  function automatic logic usink(mfs_pkg::mfs_micro_t m);
    return mv(m) && !tape(m) && m[6:2] == `MFS_DST_MICRO;
  endfunction
  function automatic int unsigned lenp(mfs_pkg::mfs_micro_t m);
    return (dec(m) && mar(m)) ? 5 : mar(m) ? 4 : dec(m) ? 3 : 2;
  endfunction
  function automatic mfs_pkg::mfs_micro_t mk(logic [4:0] s, logic [4:0] d,
                                              logic [1:0] w);
    return {`MFS_OP_MOVE, s, d, w};
  endfunction
  function automatic mfs_pkg::mfs_micro_t gen();
    logic [4:0] s;
    s = 5'($urandom_range(0, 31));
    if (s == `MFS_SRC_TAPE) s = 5'h01;
    return {($urandom_range(0, 3) == 0) ? 4'h0 : `MFS_OP_MOVE, s,
            5'($urandom_range(0, 31)), 2'($urandom_range(0, 2))};
  endfunction

  // Width mask of a moved register
  function automatic logic [23:0] wmask(logic [1:0] w);
    return (w == `MFS_WID_16) ? 24'h00ffff :
           (w == `MFS_WID_4) ? 24'h00000f : 24'hffffff;
  endfunction

  task automatic chk_val(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_len(int unsigned got, int unsigned exp);
    num_checks++;
    if (got != exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // At each load: check the loaded micro and the length, plan the next
  task automatic on_start();
    mfs_pkg::mfs_micro_t pick;
    logic [23:0] ex;
    logic        b;
    int unsigned j;
    if (started) begin
      chk_val(32'(ureg), 32'(exp_nxt));
      chk_len(cyc - c0, seg_len);
    end
    started = 1'b1;
    c0 = cyc;
    n_pulse++;
    tape_on = 1'b0;
    part2 = mar_mid;
    if (mar_mid) begin
      mar_mid = 1'b0;
      seg_len = 2 * P;
    end else begin
      cur = exp_nxt;
      seg_len = lenp(cur) * P;
      if (mar(cur)) begin
        mar_mid = 1'b1;
        seg_len = (dec(cur) ? 3 : 2) * P;
      end
    end
    if (tape(cur) && !part2) begin
      j = $urandom_range(1, 3);
      tape_at = cyc + j * P + 6;
      tape_on = 1'b1;
      seg_len = (j + 3) * P;
    end else if (!mar_mid && !part2 && $urandom_range(0, 3) == 0) begin
      ref_at = cyc + 3;
      seg_len += 2 * P;
    end
    // Word read ahead of an address register move is never run
    pick = (plan.size() != 0 && !mar_mid) ? plan.pop_front() : gen();
    b = 1'($urandom_range(0, 1));
    ex = 24'($urandom) & 24'hfffffc;
    ex_cur = ex;
    mar_bit4_in <= b;
    mem_word <= b ? {pick, 16'($urandom)} : {16'($urandom), pick};
    exchange_in <= ex;
    slow <= 1'($urandom_range(0, 1));
    exp_nxt = mar_mid ? cur : (pick | (usink(cur) ?
      (ex[15:0] & ((cur[1:0] == `MFS_WID_4) ? 16'h000f : 16'hffff)) : 16'h0));
  endtask

  // Phase probes at fixed offsets into the running micro
  task automatic probe(int unsigned m);
    int unsigned sk;
    sk = (2 * (dec(cur) ? 3 : 2) - 1) * H + 10;
    if (m == 10 && !part2) begin
      chk_val(32'(bus), 32'(cur));
      chk_val(32'(refused), 32'(tape(cur) && cur[6:2] == 5'h1f));
    end
    if (tape_on && m == P + 10) begin
      chk_val(32'(hold), 32'h0);
      chk_val(32'(bus), 32'h0);
      chk_val(32'(ureg), 32'(cur));
    end
    if (mv(cur) && !tape_on && !part2 && m == 40) begin
      chk_val({sen, ken, 25'h0, sa}, {2'b10, 25'h0, cur[11:7]});
    end
    if (mv(cur) && !tape_on && !part2 && m == sk) begin
      chk_val({sen, ken, wen, 24'h0, da}, {3'b011, 24'h0, cur[6:2]});
      chk_val(32'(hbuf), 32'(ex_cur & wmask(cur[1:0])));
      chk_val(32'(ureg), 32'(cur));
    end
    if (m == 40 && !part2) begin
      chk_val(32'(ph), 32'h1);
    end
    if (m == `MFS_RD_VALID_CYC - 1 || m == `MFS_RD_VALID_CYC) begin
      chk_val(32'(stb), 32'(m == `MFS_RD_VALID_CYC));
    end
    if (m == seg_len - 2) begin
      chk_val(32'(fin), 32'(!mar_mid && ref_at != c0 + 3));
    end
    if (m == seg_len - 1) begin
      chk_val(32'(mload), 32'(mar_mid));
    end
  endtask

  // Monitor and side-input drivers, all on the rising edge
  always @(posedge ref_clk_in) begin
    cyc = cyc + 1;
    refresh_req_in <= (cyc == ref_at);
    tape_full_in <= tape_on && (cyc >= tape_at);
    if (mon_en && mst === 1'b1) begin
      on_start();
    end else if (mon_en && started) begin
      probe(cyc - c0);
    end
  end

  // Main sequence: corner micros first, then random ones, then halt mode
  initial begin
    j_seed();
    plan = '{mk(5'h05, 5'h06, `MFS_WID_24),
             mk(`MFS_SRC_DEC_SUM, 5'h07, 2'h0),
             mk(`MFS_SRC_DEC_DIFF, `MFS_DST_MAR, 2'h0),
             mk(5'h08, `MFS_DST_MAR, `MFS_WID_16),
             mk(`MFS_SRC_TAPE, 5'h0b, 2'h0),
             mk(`MFS_SRC_TAPE, `MFS_DST_MICRO, 2'h1), `MFS_NOOP,
             mk(5'h0a, `MFS_DST_MICRO, `MFS_WID_4),
             mk(5'h09, `MFS_DST_MICRO, `MFS_WID_16),
             mk(`MFS_SRC_DEC_SUM, `MFS_DST_MICRO, `MFS_WID_24)};
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(negedge ref_clk_in);
    mon_en = 1'b1;
    while (n_pulse < 45) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    mon_en = 1'b0;
    @(posedge ref_clk_in);
    run_state_level_in <= 1'b0;
    halt_mode_in <= 1'b1;
    halt_micro_in <= 16'($urandom);
    repeat (3) @(posedge ref_clk_in);
    chk_val(32'(bus), 32'(halt_micro_in));
    halt_mode_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    chk_val(32'(bus), 32'h0);
    stop_test();
  end

  task automatic j_seed();
    int unsigned s;
    s = $urandom(32'h979dc9b5);
    {started, mar_mid, part2, tape_on, mon_en} = 5'h00;
    {cyc, n_pulse, fail_count, num_checks, c0} = '0;
    exp_nxt = `MFS_NOOP;
  endtask

  // Watchdog well beyond the expected run of about 8000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    fail_count++;
    stop_test();
  end
endmodule
